/* File: logic/daasm_top.sv */
`timescale 1ns/100ps
module daasm_top (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic sel_n,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   input wire daasm_pkg::daasm_fault_s faults,
   input wire daasm_pkg::daasm_meas_s meas,
   output logic selftest_en,
   output logic [2:0] payload_type,
   output logic cmd_err,
   output logic frame_done,
   output logic frame_drop
);

   logic [2:0] pins_s;
   logic sel_n_s;
   logic sclk_s;
   logic mosi_s;

   daasm_sync #(
      .W(3),
      .RST_VAL(daasm_pkg::PIN_IDLE)
   ) u_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .d({sel_n, sclk, mosi}),
      .q(pins_s)
   );

   assign sel_n_s = pins_s[2];
   assign sclk_s = pins_s[1];
   assign mosi_s = pins_s[0];

   logic sclk_q_r;
   logic sel_q_r;
   logic rise;
   logic fall;
   logic start;
   logic stop;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sclk_q_r <= 1'b0;
         sel_q_r <= 1'b1;
      end else begin
         sclk_q_r <= sclk_s;
         sel_q_r <= sel_n_s;
      end
   end

   assign rise = sclk_s & ~sclk_q_r;
   assign fall = ~sclk_s & sclk_q_r;
   assign start = ~sel_n_s & sel_q_r;
   assign stop = sel_n_s & ~sel_q_r;

   daasm_pkg::daasm_link_e link_r, link_nxt;
   logic [daasm_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [daasm_pkg::FRAME_W-1:0] rx_r, rx_nxt;
   logic [daasm_pkg::FRAME_W-1:0] tx_r, tx_nxt;
   logic miso_r, miso_nxt;
   logic oe_r, oe_nxt;
   logic [2:0] type_r, type_nxt;
   logic cbit_r, cbit_nxt;
   logic cerr_r, cerr_nxt;
   logic done_r, done_nxt;
   logic drop_r, drop_nxt;

   logic [7:0] stat_byte;
   logic [7:0] detail_byte;
   logic [31:0] data_bytes;
   logic [7:0] tx_csum;
   logic [7:0] rx_csum;
   logic [daasm_pkg::FRAME_W-1:0] tx_frame;
   logic [7:0] rx_cmd;
   logic csum_ok;
   logic cmd_known;
   logic full_frame;

   // Reply image built from the state left by the previous frame
   always_comb begin
      stat_byte = {faults.bit_fail, faults.y_fail, faults.x_fail,
                   cerr_r, cbit_r, type_r};
      detail_byte = {faults.x_fail, faults.y_fail, faults.vref_fail,
                     faults.cap_fail, cbit_r, faults.otp_fail,
                     cerr_r, 1'b0};
      if (type_r == daasm_pkg::TYPE_ACC) begin
         data_bytes = {meas.acc_y, meas.acc_x};
      end else begin
         data_bytes = {detail_byte, daasm_pkg::PAD_BYTE, meas.temp};
      end
   end

   // Data and status are taken in the same cycle as the sum, so they agree
   daasm_csum u_tx_csum (
      .bytes({stat_byte, data_bytes}),
      .csum(tx_csum)
   );

   assign tx_frame = {stat_byte, data_bytes, tx_csum};

   daasm_csum u_rx_csum (
      .bytes(rx_r[daasm_pkg::FRAME_W-1:daasm_pkg::BYTE_W]),
      .csum(rx_csum)
   );

   assign rx_cmd = rx_r[daasm_pkg::FRAME_W-1 -: daasm_pkg::BYTE_W];
   assign csum_ok = (rx_csum == rx_r[daasm_pkg::BYTE_W-1:0]);
   assign cmd_known = (rx_cmd == daasm_pkg::CMD_ACC) ||
                      (rx_cmd == daasm_pkg::CMD_STAT) ||
                      (rx_cmd == daasm_pkg::CMD_ACC_ST) ||
                      (rx_cmd == daasm_pkg::CMD_STAT_ST);
   assign full_frame = (cnt_r == daasm_pkg::FRAME_BITS);

   always_comb begin
      link_nxt = link_r;
      cnt_nxt = cnt_r;
      rx_nxt = rx_r;
      tx_nxt = tx_r;
      miso_nxt = miso_r;
      oe_nxt = oe_r;
      type_nxt = type_r;
      cbit_nxt = cbit_r;
      cerr_nxt = cerr_r;
      done_nxt = 1'b0;
      drop_nxt = 1'b0;
      unique case (link_r)
         daasm_pkg::LINK_IDLE: begin
            if (start) begin
               tx_nxt = tx_frame;
               miso_nxt = tx_frame[daasm_pkg::FRAME_W-1];
               oe_nxt = 1'b1;
               cnt_nxt = daasm_pkg::CNT_ZERO;
               link_nxt = daasm_pkg::LINK_SHIFT;
            end
         end
         daasm_pkg::LINK_SHIFT: begin
            if (stop) begin
               oe_nxt = 1'b0;
               link_nxt = daasm_pkg::LINK_IDLE;
               if (full_frame) begin
                  cerr_nxt = ~csum_ok;
                  if (csum_ok && cmd_known) begin
                     type_nxt = rx_cmd[2:0];
                     cbit_nxt = rx_cmd[daasm_pkg::CMD_ST_BIT];
                     done_nxt = 1'b1;
                  end else begin
                     drop_nxt = 1'b1;
                  end
               end else begin
                  drop_nxt = 1'b1;
               end
            end else begin
               if (rise) begin
                  rx_nxt = {rx_r[daasm_pkg::FRAME_W-2:0], mosi_s};
                  // Saturate so an overlong frame never looks complete
                  if (cnt_r != daasm_pkg::CNT_MAX) begin
                     cnt_nxt = daasm_pkg::CNT_W'(cnt_r + daasm_pkg::CNT_ONE);
                  end
               end
               // Mode 0: next bit goes out on the falling edge
               if (fall && (cnt_r != daasm_pkg::CNT_ZERO)) begin
                  tx_nxt = {tx_r[daasm_pkg::FRAME_W-2:0], 1'b0};
                  miso_nxt = tx_r[daasm_pkg::FRAME_W-2];
               end
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         link_r <= daasm_pkg::LINK_IDLE;
         cnt_r <= daasm_pkg::CNT_ZERO;
         rx_r <= '0;
         tx_r <= '0;
         miso_r <= 1'b0;
         oe_r <= 1'b0;
         type_r <= daasm_pkg::TYPE_ACC;
         cbit_r <= 1'b0;
         cerr_r <= 1'b0;
         done_r <= 1'b0;
         drop_r <= 1'b0;
      end else begin
         link_r <= link_nxt;
         cnt_r <= cnt_nxt;
         rx_r <= rx_nxt;
         tx_r <= tx_nxt;
         miso_r <= miso_nxt;
         oe_r <= oe_nxt;
         type_r <= type_nxt;
         cbit_r <= cbit_nxt;
         cerr_r <= cerr_nxt;
         done_r <= done_nxt;
         drop_r <= drop_nxt;
      end
   end

   assign miso = miso_r;
   assign miso_oe = oe_r;
   assign selftest_en = cbit_r;
   assign payload_type = type_r;
   assign cmd_err = cerr_r;
   assign frame_done = done_r;
   assign frame_drop = drop_r;

   logic [7:0] tx_sum;
   logic frame_end;

   always_comb begin
      tx_sum = '0;
      for (int i = 0; i < daasm_pkg::FRAME_BYTES; i++) begin
         tx_sum = daasm_pkg::BYTE_W'(tx_sum +
            tx_r[i*daasm_pkg::BYTE_W +: daasm_pkg::BYTE_W]);
      end
   end

   assign frame_end = stop && (link_r == daasm_pkg::LINK_SHIFT);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   AST_OE_FRAME: assert property (
      (link_r == daasm_pkg::LINK_IDLE && start) |=> oe_r [*2] ##0
      (link_r == daasm_pkg::LINK_SHIFT))
      else $error("Output enable not raised at frame start");
   AST_OE_RELEASE: assert property (frame_end |=> !oe_r && !miso_oe)
      else $error("Output enable not dropped at frame end");
   AST_FIRST_BIT: assert property (
      (link_r == daasm_pkg::LINK_IDLE && start) |=>
      miso_r == $past(stat_byte[7]))
      else $error("First reply bit is not status bit 7");
   AST_STAT_FLAGS: assert property (
      (link_r == daasm_pkg::LINK_IDLE && start) |=>
      tx_r[44] == $past(cerr_r) && tx_r[43] == $past(cbit_r) &&
      tx_r[42:40] == $past(type_r))
      else $error("Status byte flags wrong");
   AST_TX_SUM: assert property (
      (link_r == daasm_pkg::LINK_SHIFT && cnt_r == daasm_pkg::CNT_ZERO) |->
      tx_sum == daasm_pkg::SUM_ALL_ONES)
      else $error("Reply checksum wrong");
   AST_ACC_DATA: assert property (
      (link_r == daasm_pkg::LINK_IDLE && start &&
       type_r == daasm_pkg::TYPE_ACC) |=>
      tx_r[39:8] == $past({meas.acc_y, meas.acc_x}))
      else $error("Acceleration payload wrong");
   AST_STAT_DATA: assert property (
      (link_r == daasm_pkg::LINK_IDLE && start &&
       type_r == daasm_pkg::TYPE_STAT) |=>
      tx_r[31:24] == daasm_pkg::PAD_BYTE && tx_r[23:8] == $past(meas.temp))
      else $error("Status payload wrong");
   AST_BAD_SUM: assert property (
      (frame_end && full_frame && !csum_ok) |=>
      cerr_r && $stable(type_r) && $stable(cbit_r) && frame_drop)
      else $error("Bad checksum frame not rejected");
   AST_GOOD_CMD: assert property (
      (frame_end && full_frame && csum_ok &&
       rx_cmd == daasm_pkg::CMD_STAT_ST) |=>
      type_r == daasm_pkg::TYPE_STAT && cbit_r && !cerr_r && frame_done)
      else $error("Good command not applied");
   AST_PARTIAL: assert property (
      (frame_end && !full_frame) |=>
      $stable(type_r) && $stable(cerr_r) && frame_drop)
      else $error("Partial frame changed state");
   AST_RX_SHIFT: assert property (
      (link_r == daasm_pkg::LINK_SHIFT && rise && !stop) |=>
      rx_r[0] == $past(mosi_s))
      else $error("Input bit not taken on rising edge");
   AST_TYPE_LEGAL: assert property (
      type_r == daasm_pkg::TYPE_ACC || type_r == daasm_pkg::TYPE_STAT)
      else $error("Illegal payload type held");

   COV_GOOD: cover property (frame_end && full_frame && csum_ok);
   COV_BAD: cover property (frame_end && full_frame && !csum_ok);
   COV_PARTIAL: cover property (frame_end && !full_frame);
   COV_SELFTEST: cover property (frame_done ##1 selftest_en);

endmodule

/* File: inc/daasm_pkg.sv */
package daasm_pkg;

   localparam int BYTE_W = 8;
   localparam int FRAME_BYTES = 6;
   localparam int SUM_BYTES = 5;
   localparam int FRAME_W = FRAME_BYTES * BYTE_W;
   localparam int SUM_W = SUM_BYTES * BYTE_W;
   localparam int CNT_W = 6;

   localparam logic [CNT_W-1:0] FRAME_BITS = 6'h30;
   localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

   localparam logic [7:0] CMD_ACC = 8'h01;
   localparam logic [7:0] CMD_STAT = 8'h02;
   localparam logic [7:0] CMD_ACC_ST = 8'h41;
   localparam logic [7:0] CMD_STAT_ST = 8'h42;
   localparam int CMD_ST_BIT = 6;

   localparam logic [2:0] TYPE_ACC = 3'h1;
   localparam logic [2:0] TYPE_STAT = 3'h2;
   localparam logic [7:0] PAD_BYTE = 8'h00;
   localparam logic [7:0] SUM_ALL_ONES = 8'hFF;

   // Idle levels of the serial pins: select, clock, data in
   localparam logic [2:0] PIN_IDLE = 3'h5;

   typedef enum logic {
      LINK_IDLE,
      LINK_SHIFT
   } daasm_link_e;

   typedef struct packed {
      logic bit_fail;
      logic y_fail;
      logic x_fail;
      logic vref_fail;
      logic cap_fail;
      logic otp_fail;
   } daasm_fault_s;

   typedef struct packed {
      logic [15:0] acc_y;
      logic [15:0] acc_x;
      logic [15:0] temp;
   } daasm_meas_s;

endpackage

/* File: logic/daasm_sync.sv */
`timescale 1ns/100ps
module daasm_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end

   assign q = s2_r;

endmodule

/* File: logic/daasm_csum.sv */
`timescale 1ns/100ps
module daasm_csum (
   input wire logic [daasm_pkg::SUM_W-1:0] bytes,
   output logic [daasm_pkg::BYTE_W-1:0] csum
);

   always_comb begin
      logic [daasm_pkg::BYTE_W-1:0] acc;
      acc = '0;
      // Carries out of bit 7 are dropped on purpose
      for (int i = 0; i < daasm_pkg::SUM_BYTES; i++) begin
         acc = daasm_pkg::BYTE_W'(acc + bytes[i*daasm_pkg::BYTE_W +:
                                              daasm_pkg::BYTE_W]);
      end
      csum = ~acc;
   end

endmodule

/* File: bench/daasm_host.sv */
`timescale 1ns/100ps
module daasm_host (
   input wire logic ref_clk,
   output logic sel_n,
   output logic sclk,
   output logic mosi,
   input wire logic miso
);
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b1;
   end
   // Mode 0 master: data moves on fall, sampled on rise
   task automatic xfer(input logic [47:0] tx, input int n,
         output logic [47:0] rx);
      rx = '0;
      @(negedge ref_clk) sel_n = 1'b0;
      repeat (6) @(negedge ref_clk);
      for (int i = 0; i < n; i++) begin
         mosi = tx[47-i];
         repeat (4) @(negedge ref_clk);
         sclk = 1'b1;
         rx = {rx[46:0], miso};
         repeat (4) @(negedge ref_clk);
         sclk = 1'b0;
      end
      repeat (4) @(negedge ref_clk);
      sel_n = 1'b1;
      // Released line floats to its pull-up
      mosi = 1'b1;
      repeat (8) @(negedge ref_clk);
   endtask
endmodule

/* File: bench/test_daasm_top.sv */
`timescale 1ns/100ps
module test_daasm_top;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic sel_n, sclk, mosi, miso, miso_oe, miso_w;
   daasm_pkg::daasm_fault_s faults = '0;
   daasm_pkg::daasm_meas_s meas = '0;
   logic selftest_en, cmd_err, frame_done, frame_drop;
   logic [2:0] payload_type;
   int fail_count = 0;
   int cmp_count = 0;
   int done_n = 0;
   int drop_n = 0;
   int done_e = 0;
   int drop_e = 0;
   logic [2:0] typ_m = daasm_pkg::TYPE_ACC;
   logic st_m = 1'b0;
   logic err_m = 1'b0;
   logic [47:0] rx;
   // Command, checksum, expected {err, selftest, type}; row 3 bad sum
   logic [23:0] rows [7] = '{24'h01FE01, 24'h42BD0A, 24'h41BE09,
      24'h02FE19, 24'h02FD02, 24'h07F802, 24'h01FE01};

   always #25 ref_clk = ~ref_clk;
   // Undriven output shows the inverse of the held bit, never the bit itself
   assign miso_w = miso_oe ? miso : ~miso;
   always @(posedge ref_clk) begin
      if (frame_done === 1'b1) done_n++;
      if (frame_drop === 1'b1) drop_n++;
   end

   daasm_top i_daasm_top (.ref_clk(ref_clk), .nrst(nrst),
      .sel_n(sel_n), .sclk(sclk), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe), .faults(faults), .meas(meas),
      .selftest_en(selftest_en), .payload_type(payload_type),
      .cmd_err(cmd_err), .frame_done(frame_done),
      .frame_drop(frame_drop));
   daasm_host i_daasm_host (.ref_clk(ref_clk), .sel_n(sel_n),
      .sclk(sclk), .mosi(mosi), .miso(miso_w));

   function automatic logic [7:0] csum(input logic [39:0] b);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < 5; i++) s += b[8*i +: 8];
      return ~s;
   endfunction

   function automatic logic [47:0] reply();
      logic [7:0] st;
      logic [7:0] det;
      logic [31:0] d;
      st = {faults.bit_fail, faults.y_fail, faults.x_fail, err_m,
         st_m, typ_m};
      det = {faults.x_fail, faults.y_fail, faults.vref_fail,
         faults.cap_fail, st_m, faults.otp_fail, err_m, 1'b0};
      if (typ_m == daasm_pkg::TYPE_ACC) d = {meas.acc_y, meas.acc_x};
      else d = {det, 8'h00, meas.temp};
      return {st, d, csum({st, d})};
   endfunction

   task automatic chk_frame(input string nm, input logic [47:0] e,
         input logic [47:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chk_lvl(input string nm, input logic [7:0] e,
         input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic frame(input logic [15:0] r, input int n);
      logic [47:0] e;
      logic [7:0] c;
      e = reply();
      c = r[15:8];
      fork
         i_daasm_host.xfer({c, 32'h0, r[7:0]}, n, rx);
         begin
            // Data moving mid-frame must not reach the reply
            repeat (20) @(negedge ref_clk);
            meas = ~meas;
         end
      join
      if (n != 48) drop_e++;
      else begin
         chk_frame("reply", e, rx);
         err_m = csum({c, 32'h0}) !== r[7:0];
         if (err_m || !(c inside {daasm_pkg::CMD_ACC, daasm_pkg::CMD_STAT,
               daasm_pkg::CMD_ACC_ST, daasm_pkg::CMD_STAT_ST}))
            drop_e++;
         else begin
            done_e++;
            typ_m = c[2:0];
            st_m = c[6];
         end
      end
      chk_lvl("type", 8'(typ_m), 8'(payload_type));
      chk_lvl("selftest", 8'(st_m), 8'(selftest_en));
      chk_lvl("cmd_err", 8'(err_m), 8'(cmd_err));
      chk_lvl("done", 8'(done_e), 8'(done_n));
      chk_lvl("drop", 8'(drop_e), 8'(drop_n));
      chk_lvl("oe", 8'h00, 8'(miso_oe));
   endtask

   task automatic idle_chk();
      chk_lvl("type", 8'(daasm_pkg::TYPE_ACC), 8'(payload_type));
      chk_lvl("selftest", 8'h00, 8'(selftest_en));
      chk_lvl("cmd_err", 8'h00, 8'(cmd_err));
      chk_lvl("oe", 8'h00, 8'(miso_oe));
   endtask

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      #2000000;
      fail_count++;
      print_verdict();
   end

   initial begin
      repeat (16) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (4) @(negedge ref_clk);
      idle_chk();
      for (int i = 0; i < 7; i++) begin
         faults = daasm_pkg::daasm_fault_s'(6'h01 << (i % 6));
         // Distinct high and low bytes, acc_y and temp negative, acc_x positive
         meas = {8'h80, 8'(i), 8'h7F, 8'(i + 8), 8'hFF, 8'(i + 16)};
         frame(rows[i][23:8], 48);
         chk_lvl("row", rows[i][7:0],
            {3'h0, cmd_err, selftest_en, payload_type});
      end
      // Short frame must leave the selection alone
      frame(16'h02FD, 24);
      frame(16'h42BD, 48);
      frame(16'h42BD, 48);
      // Reset in mid-run returns to power-up selection
      nrst = 1'b0;
      repeat (2) @(negedge ref_clk);
      idle_chk();
      nrst = 1'b1;
      typ_m = daasm_pkg::TYPE_ACC;
      st_m = 1'b0;
      err_m = 1'b0;
      repeat (4) @(negedge ref_clk);
      frame(16'h02FD, 48);
      print_verdict();
   end
endmodule
